// ==== cfg_access_pkg.sv ====
// Shared constants, types and helpers for the configuration access message link
package cfg_access_pkg;
   // Control token codes
   localparam logic [7:0] CT_WRITE = 8'hC0; // 192
   localparam logic [7:0] CT_READ = 8'hC1; // 193
   localparam logic [7:0] CT_END = 8'h01;
   localparam logic [7:0] CT_ACK = 8'h03;
   localparam logic [7:0] CT_NACK = 8'h04;
   // Reply suppression marker in the low byte of the reply identifier
   localparam logic [7:0] NO_REPLY_LOW = 8'hFF;
   // Channel destination low halves for the two banks
   localparam logic [15:0] TILE_DEST_LOW = 16'hC20C;
   localparam logic [15:0] NODE_DEST_LOW = 16'hC30C;
   // Processor-status resource identifier parts
   localparam logic [7:0] PS_RES_LOW = 8'h0B;
   localparam int PS_SHIFT = 8;
   // Last byte index of each field and message lengths in tokens
   localparam logic [3:0] RID_LAST = 4'h2;
   localparam logic [3:0] REG_LAST = 4'h1;
   localparam logic [3:0] DATA_LAST = 4'h3;
   localparam logic [3:0] WR_MSG_LEN = 4'hB;
   localparam logic [3:0] RD_MSG_LEN = 4'h7;
   // Storage sizes
   localparam int REG_COUNT = 16;
   localparam int PS_COUNT = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int TOK_W = 9;

   // One link token: control flag plus byte
   typedef struct packed {
      logic ctrl;
      logic [7:0] data;
   } tok_t;

   // Resource identifier of a processor status register
   function automatic logic [31:0] ps_resource_id(input logic [23:0] regn);
      ps_resource_id = ({8'h00, regn} << PS_SHIFT) | {24'h000000, PS_RES_LOW};
   endfunction : ps_resource_id

   // Register number legal in a bank of the given size
   function automatic logic reg_known(input logic [23:0] regn, input int count);
      reg_known = (regn < 24'(count));
   endfunction : reg_known
endpackage : cfg_access_pkg

// ==== cfg_link_if.sv ====
// Token link between a configuration requester and the configuration access device
`timescale 1ns/1ps
interface cfg_link_if;
   import cfg_access_pkg::*;
   logic req_valid;
   logic req_ready;
   tok_t req_tok;
   logic [31:0] req_dest;
   logic rsp_valid;
   logic rsp_ready;
   tok_t rsp_tok;
   logic [23:0] rsp_dest;

   modport dev (input req_valid, output req_ready, input req_tok, input req_dest,
                output rsp_valid, input rsp_ready, output rsp_tok, output rsp_dest);
   modport host (output req_valid, input req_ready, output req_tok, output req_dest,
                 input rsp_valid, output rsp_ready, input rsp_tok, input rsp_dest);
endinterface : cfg_link_if

// ==== cfg_access_dev.sv ====
// Configuration access device end: request FIFO, message parser, register banks, replier
//
// Function
// - Write: token 192, id, register, data, 1
// - Read: token 193, id, register, 1
// - Write reply: 3,1 success; 4,1 failure
// - Read reply: 3, data, 1; or 4,1
// - Multi-byte fields travel most significant byte first
// - Requester supplies its 24-bit reply identifier
// - Write with id low byte FF: no reply
// - Tile bank destination low bits C20C
// - Node bank destination low bits C30C
// - Status resource id is reg<<8 OR 0x0B
// - Status read and write move whole words
`timescale 1ns/1ps
module cfg_req_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] count;
      logic full;
      logic empty;
   } fifo_s_t;
   fifo_s_t q, d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   assign in_ready = !q.full;
   assign out_valid = !q.empty;
   assign out_data = mem[q.rp];
   assign push = in_valid && !q.full;
   assign pop = out_ready && !q.empty;

   // Pointer and occupancy update; flags registered so ready leaves a flop
   always_comb begin
      d = q;
      if (push) begin
         d.wp = q.wp + 1'b1;
      end
      if (pop) begin
         d.rp = q.rp + 1'b1;
      end
      d.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
      d.full = (d.count == (AW+1)'(DEPTH));
      d.empty = (d.count == '0);
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         q <= '{wp: '0, rp: '0, count: '0, full: 1'b0, empty: 1'b1};
      end else begin
         q <= d;
      end
      if (push) begin
         mem[q.wp] <= in_data;
      end
   end
endmodule : cfg_req_fifo

module cfg_access_dev
   import cfg_access_pkg::*;
#(
   parameter logic [15:0] BANK_DEST_LOW = TILE_DEST_LOW
) (
   input wire logic clock,
   input wire logic rstn,
   cfg_link_if.dev link,
   input wire logic ps_valid,
   input wire logic ps_write,
   input wire logic [31:0] ps_resid,
   input wire logic [31:0] ps_wdata,
   output logic ps_ack,
   output logic ps_err,
   output logic [31:0] ps_rdata
);
   typedef enum logic [3:0] {
      S_IDLE = 4'b0000,
      S_RID = 4'b0001,
      S_REG = 4'b0010,
      S_DATA = 4'b0011,
      S_END = 4'b0100,
      S_SKIP = 4'b0101,
      S_EXEC = 4'b0110,
      S_RSP_HEAD = 4'b0111,
      S_RSP_DATA = 4'b1000,
      S_RSP_END = 4'b1001
   } dev_state_t;

   typedef struct packed {
      dev_state_t st;
      logic [3:0] cnt;
      logic wr;
      logic err;
      logic ok;
      logic [23:0] rid;
      logic [15:0] regn;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic rsp_valid;
      tok_t rsp_tok;
      logic [23:0] rsp_dest;
      logic ps_ack;
      logic ps_err;
      logic [31:0] ps_rdata;
   } dev_s_t;

   dev_s_t q, d;
   logic [31:0] cfg_mem [REG_COUNT];
   logic [31:0] ps_mem [PS_COUNT];
   logic f_valid, f_pop, f_match;
   tok_t f_tok;
   logic cfg_we, ps_we, slot_free, ps_ok;
   logic [23:0] ps_regn;

   // Incoming tokens queue here; a reply in progress stalls draining, back-pressuring the link
   cfg_req_fifo #(.WIDTH(TOK_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rstn(rstn),
      .in_valid(link.req_valid),
      .in_ready(link.req_ready),
      .in_data({(link.req_dest[15:0] == BANK_DEST_LOW), link.req_tok}),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data({f_match, f_tok})
   );

   assign link.rsp_valid = q.rsp_valid;
   assign link.rsp_tok = q.rsp_tok;
   assign link.rsp_dest = q.rsp_dest;
   assign ps_ack = q.ps_ack;
   assign ps_err = q.ps_err;
   assign ps_rdata = q.ps_rdata;
   assign slot_free = !q.rsp_valid || link.rsp_ready;
   assign ps_regn = ps_resid[31:8];
   assign ps_ok = (ps_resid == ps_resource_id(ps_regn))
                  && reg_known(ps_regn, PS_COUNT);

   // Parser, executor and replier
   always_comb begin
      d = q;
      f_pop = 1'b0;
      cfg_we = 1'b0;
      ps_we = 1'b0;
      if (q.rsp_valid && link.rsp_ready) begin
         d.rsp_valid = 1'b0;
      end
      case (q.st)
         S_IDLE: begin
            // Stray tokens between messages are dropped
            f_pop = f_valid;
            if (f_valid && f_tok.ctrl && f_match &&
                (f_tok.data == CT_WRITE || f_tok.data == CT_READ)) begin
               d.wr = (f_tok.data == CT_WRITE);
               d.err = 1'b0;
               d.cnt = '0;
               d.st = S_RID;
            end
         end
         S_RID, S_REG, S_DATA: begin
            f_pop = f_valid;
            if (f_valid && f_tok.ctrl) begin
               // Early control token: failure, resync on the end token
               d.err = 1'b1;
               d.st = (f_tok.data == CT_END) ? S_EXEC : S_SKIP;
            end else if (f_valid) begin
               d.cnt = q.cnt + 4'h1;
               if (q.st == S_RID) begin
                  d.rid = {q.rid[15:0], f_tok.data};
                  if (q.cnt == RID_LAST) begin
                     d.cnt = '0;
                     d.st = S_REG;
                  end
               end else if (q.st == S_REG) begin
                  d.regn = {q.regn[7:0], f_tok.data};
                  if (q.cnt == REG_LAST) begin
                     d.cnt = '0;
                     d.st = q.wr ? S_DATA : S_END;
                  end
               end else begin
                  d.wdata = {q.wdata[23:0], f_tok.data};
                  if (q.cnt == DATA_LAST) begin
                     d.st = S_END;
                  end
               end
            end
         end
         S_END: begin
            f_pop = f_valid;
            if (f_valid) begin
               if (f_tok.ctrl && f_tok.data == CT_END) begin
                  d.st = S_EXEC;
               end else begin
                  d.err = 1'b1;
                  d.st = S_SKIP;
               end
            end
         end
         S_SKIP: begin
            f_pop = f_valid;
            if (f_valid && f_tok.ctrl && f_tok.data == CT_END) begin
               d.st = S_EXEC;
            end
         end
         S_EXEC: begin
            d.ok = !q.err && reg_known({8'h00, q.regn}, REG_COUNT);
            cfg_we = d.ok && q.wr;
            d.rdata = cfg_mem[q.regn[3:0]];
            d.cnt = '0;
            if (q.wr && q.rid[7:0] == NO_REPLY_LOW) begin
               d.st = S_IDLE;
            end else begin
               d.st = S_RSP_HEAD;
            end
         end
         S_RSP_HEAD: begin
            if (slot_free) begin
               d.rsp_valid = 1'b1;
               d.rsp_tok = '{ctrl: 1'b1, data: q.ok ? CT_ACK : CT_NACK};
               d.rsp_dest = q.rid;
               d.st = (q.ok && !q.wr) ? S_RSP_DATA : S_RSP_END;
            end
         end
         S_RSP_DATA: begin
            if (slot_free) begin
               d.rsp_valid = 1'b1;
               d.rsp_tok = '{ctrl: 1'b0, data: q.rdata[31:24]};
               d.rdata = {q.rdata[23:0], 8'h00};
               d.cnt = q.cnt + 4'h1;
               if (q.cnt == DATA_LAST) begin
                  d.st = S_RSP_END;
               end
            end
         end
         S_RSP_END: begin
            if (slot_free) begin
               d.rsp_valid = 1'b1;
               d.rsp_tok = '{ctrl: 1'b1, data: CT_END};
               d.st = S_IDLE;
            end
         end
         default: begin
            d.st = S_IDLE;
         end
      endcase
      // Processor status port: one full word per access, answered next cycle
      d.ps_ack = ps_valid;
      d.ps_err = ps_valid && !ps_ok;
      if (ps_valid && ps_ok) begin
         ps_we = ps_write;
         d.ps_rdata = ps_write ? q.ps_rdata : ps_mem[ps_regn[3:0]];
      end
   end

   // State and register bank storage; bank contents are not reset
   always_ff @(posedge clock) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
      if (cfg_we) begin
         cfg_mem[q.regn[3:0]] <= q.wdata;
      end
      if (ps_we) begin
         ps_mem[ps_regn[3:0]] <= ps_wdata;
      end
   end
endmodule : cfg_access_dev

// ==== cfg_access_host.sv ====
// Configuration requester end: serialises commands into token messages and parses replies
`timescale 1ns/1ps
module cfg_access_host
   import cfg_access_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   cfg_link_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic cmd_node_bank,
   input wire logic [15:0] cmd_target_id,
   input wire logic [15:0] cmd_reg,
   input wire logic [31:0] cmd_wdata,
   input wire logic [23:0] cmd_reply_id,
   output logic res_valid,
   output logic res_ok,
   output logic [31:0] res_rdata
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_SEND = 3'b001,
      H_WAIT = 3'b010,
      H_RDATA = 3'b011,
      H_REND = 3'b100,
      H_DONE = 3'b101
   } host_state_t;

   typedef struct packed {
      host_state_t st;
      logic [3:0] idx;
      logic [3:0] cnt;
      logic wr;
      logic [23:0] rid;
      logic [15:0] regn;
      logic [31:0] wdata;
      logic ack;
      logic [31:0] rdata;
      logic req_valid;
      tok_t req_tok;
      logic [31:0] req_dest;
      logic rsp_ready;
      logic cmd_ready;
      logic res_valid;
      logic res_ok;
      logic [31:0] res_rdata;
   } host_s_t;

   host_s_t q, d;
   logic rsp_take;

   // Token at position idx of a request message
   function automatic tok_t req_token(input logic wr, input logic [23:0] rid,
                                      input logic [15:0] regn, input logic [31:0] wdata,
                                      input logic [3:0] idx);
      logic [7:0] bytes [11];
      bytes[0] = wr ? CT_WRITE : CT_READ;
      bytes[1] = rid[23:16];
      bytes[2] = rid[15:8];
      bytes[3] = rid[7:0];
      bytes[4] = regn[15:8];
      bytes[5] = regn[7:0];
      bytes[6] = wr ? wdata[31:24] : CT_END;
      bytes[7] = wdata[23:16];
      bytes[8] = wdata[15:8];
      bytes[9] = wdata[7:0];
      bytes[10] = CT_END;
      req_token.data = bytes[idx];
      req_token.ctrl = (idx == 4'h0) || (idx == (wr ? WR_MSG_LEN : RD_MSG_LEN) - 4'h1);
   endfunction : req_token

   assign link.req_valid = q.req_valid;
   assign link.req_tok = q.req_tok;
   assign link.req_dest = q.req_dest;
   assign link.rsp_ready = q.rsp_ready;
   assign cmd_ready = q.cmd_ready;
   assign res_valid = q.res_valid;
   assign res_ok = q.res_ok;
   assign res_rdata = q.res_rdata;
   assign rsp_take = link.rsp_valid && q.rsp_ready;

   // Command sequencer and reply parser
   always_comb begin
      d = q;
      d.res_valid = 1'b0;
      case (q.st)
         H_IDLE: begin
            d.cmd_ready = 1'b1;
            if (cmd_valid && q.cmd_ready) begin
               d.cmd_ready = 1'b0;
               d.wr = cmd_write;
               d.rid = cmd_reply_id;
               d.regn = cmd_reg;
               d.wdata = cmd_wdata;
               d.rdata = '0;
               d.idx = '0;
               d.req_dest = {cmd_target_id,
                  cmd_node_bank ? NODE_DEST_LOW : TILE_DEST_LOW};
               d.st = H_SEND;
            end
         end
         H_SEND: begin
            if (!q.req_valid || link.req_ready) begin
               if (q.idx == (q.wr ? WR_MSG_LEN : RD_MSG_LEN)) begin
                  d.req_valid = 1'b0;
                  d.ack = 1'b1;
                  // Suppressed reply: done as soon as the message is out
                  d.st = (q.wr && q.rid[7:0] == NO_REPLY_LOW) ? H_DONE : H_WAIT;
               end else begin
                  d.req_valid = 1'b1;
                  d.req_tok = req_token(q.wr, q.rid, q.regn, q.wdata, q.idx);
                  d.idx = q.idx + 4'h1;
               end
            end
         end
         H_WAIT: begin
            if (rsp_take && link.rsp_tok.ctrl) begin
               d.cnt = '0;
               if (link.rsp_tok.data == CT_ACK) begin
                  d.ack = 1'b1;
                  d.st = q.wr ? H_REND : H_RDATA;
               end else if (link.rsp_tok.data == CT_NACK) begin
                  d.ack = 1'b0;
                  d.st = H_REND;
               end
            end
         end
         H_RDATA: begin
            if (rsp_take && link.rsp_tok.ctrl) begin
               // Truncated data: treat as failure
               d.ack = 1'b0;
               d.st = (link.rsp_tok.data == CT_END) ? H_DONE : H_REND;
            end else if (rsp_take) begin
               d.rdata = {q.rdata[23:0], link.rsp_tok.data};
               d.cnt = q.cnt + 4'h1;
               if (q.cnt == DATA_LAST) begin
                  d.st = H_REND;
               end
            end
         end
         H_REND: begin
            if (rsp_take) begin
               if (!(link.rsp_tok.ctrl && link.rsp_tok.data == CT_END)) begin
                  d.ack = 1'b0;
               end else begin
                  d.st = H_DONE;
               end
            end
         end
         H_DONE: begin
            d.res_valid = 1'b1;
            d.res_ok = q.ack;
            d.res_rdata = q.rdata;
            d.st = H_IDLE;
         end
         default: begin
            d.st = H_IDLE;
         end
      endcase
      d.rsp_ready = (d.st == H_WAIT) || (d.st == H_RDATA) || (d.st == H_REND);
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : cfg_access_host

// ==== cfg_access_sva.sv ====
// Checker for the token link between the requester and the configuration device
`timescale 1ns/1ps
module cfg_access_sva
   import cfg_access_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire tok_t req_tok,
   input wire logic [31:0] req_dest,
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire tok_t rsp_tok
);
   logic [3:0] req_idx_q;
   logic [2:0] rsp_idx_q;
   logic rd_q, ok_q, sup_q;
   logic [7:0] rid_lo_q;
   wire req_fire = req_valid && req_ready;
   wire rsp_fire = rsp_valid && rsp_ready;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   // Token positions within the current request and reply
   always_ff @(posedge clock) begin
      if (!rstn) begin
         req_idx_q <= 4'h0;
         rsp_idx_q <= 3'h0;
         rd_q <= 1'b0;
         ok_q <= 1'b0;
         sup_q <= 1'b0;
         rid_lo_q <= 8'h00;
      end else begin
         if (req_fire) begin
            req_idx_q <= (req_tok.ctrl && req_idx_q != 4'h0) ? 4'h0 : req_idx_q + 4'h1;
            if (req_idx_q == 4'h0) begin
               rd_q <= req_tok.data == CT_READ;
               sup_q <= 1'b0;
            end
            if (req_idx_q == 4'h3) rid_lo_q <= req_tok.data;
            // Only a write with the marker byte goes unanswered
            if (req_tok.ctrl && req_idx_q != 4'h0) sup_q <= !rd_q && rid_lo_q == NO_REPLY_LOW;
         end
         if (rsp_fire) begin
            rsp_idx_q <= (rsp_tok.ctrl && rsp_idx_q != 3'h0) ? 3'h0 : rsp_idx_q + 3'h1;
            if (rsp_idx_q == 3'h0) ok_q <= rsp_tok.data == CT_ACK;
         end
      end
   end

   property p_req_hold;
      req_valid && !req_ready |=> req_valid && $stable(req_tok) && $stable(req_dest);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request token changed");
   property p_rsp_hold;
      rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_tok);
   endproperty
   a_rsp_hold: assert property (p_rsp_hold) else $error("reply token changed");
   property p_dest;
      req_valid |-> req_dest[15:0] == TILE_DEST_LOW || req_dest[15:0] == NODE_DEST_LOW;
   endproperty
   a_dest: assert property (p_dest) else $error("bad channel destination");
   property p_req_head;
      req_fire && req_idx_q == 4'h0 |-> req_tok.ctrl
         && (req_tok.data == CT_WRITE || req_tok.data == CT_READ);
   endproperty
   a_req_head: assert property (p_req_head) else $error("bad request head");
   property p_req_len;
      req_fire && req_tok.ctrl && req_idx_q != 4'h0 |->
         req_tok.data == CT_END && req_idx_q == (rd_q ? 4'h6 : 4'hA);
   endproperty
   a_req_len: assert property (p_req_len) else $error("bad request size");
   property p_rsp_head;
      rsp_fire && rsp_idx_q == 3'h0 |-> rsp_tok.ctrl
         && (rsp_tok.data == CT_ACK || rsp_tok.data == CT_NACK);
   endproperty
   a_rsp_head: assert property (p_rsp_head) else $error("bad reply header");
   property p_rd_data;
      rsp_fire && rd_q && ok_q && rsp_idx_q != 3'h0 && rsp_idx_q < 3'h5 |-> !rsp_tok.ctrl;
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("control token in read data");
   property p_rsp_end;
      rsp_fire && rsp_idx_q == ((rd_q && ok_q) ? 3'h5 : 3'h1) |-> rsp_tok == {1'b1, CT_END};
   endproperty
   a_rsp_end: assert property (p_rsp_end) else $error("reply end misplaced");
   property p_no_reply;
      sup_q |-> !rsp_valid;
   endproperty
   a_no_reply: assert property (p_no_reply) else $error("reply to suppressed write");
endmodule : cfg_access_sva

// ==== test_config_register_access_protocol.sv ====
// Testbench: requester and device ends joined, plus a raw driver on a node-bank device
`timescale 1ns/1ps
module test_config_register_access_protocol;
   import cfg_access_pkg::*;
   typedef struct {logic w; logic [15:0] r; logic [31:0] d; logic [23:0] id; logic ok;
      logic [31:0] rd;} row_t;
   logic clock = 0, rstn = 0, cmd_valid = 0, cmd_write = 0, ps_valid = 0, ps_write = 0;
   logic [15:0] cmd_reg = 0, tgt = 0;
   logic [31:0] cmd_wdata = 0, ps_resid = 0, ps_wdata = 0, dest2 = 32'h0000C30C, dest1, res_rdata;
   logic [31:0] ps_rdata;
   logic [23:0] cmd_reply_id = 0, rdest1;
   logic cmd_ready, res_valid, res_ok, ps_ack, ps_err, rsp_ready2 = 1, node = 0;
   logic [8:0] tx2[$], rx2[$], q1[$], ex[$];
   logic [8:0] wr_exp[11] = '{9'h1C0, 9'h012, 9'h034, 9'h05A, 9'h000, 9'h000, 9'h0A1, 9'h0B2,
      9'h0C3, 9'h0D4, 9'h101};
   row_t rows[9];
   int rcnt1 = 0, failures = 0, num_checks = 0, n, k;
   cfg_link_if l1();
   cfg_link_if l2();

   cfg_access_host i_cfg_access_host (.clock(clock), .rstn(rstn), .link(l1),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_node_bank(node),
      .cmd_target_id(tgt), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .cmd_reply_id(cmd_reply_id),
      .res_valid(res_valid), .res_ok(res_ok), .res_rdata(res_rdata));
   cfg_access_dev i_cfg_access_dev (.clock(clock), .rstn(rstn), .link(l1), .ps_valid(ps_valid),
      .ps_write(ps_write), .ps_resid(ps_resid), .ps_wdata(ps_wdata), .ps_ack(ps_ack),
      .ps_err(ps_err), .ps_rdata(ps_rdata));
   cfg_access_dev #(.BANK_DEST_LOW(NODE_DEST_LOW)) i_cfg_access_dev_node (.clock(clock),
      .rstn(rstn), .link(l2), .ps_valid(1'b0), .ps_write(1'b0), .ps_resid(32'h0),
      .ps_wdata(32'h0), .ps_ack(), .ps_err(), .ps_rdata());
   cfg_access_sva i_cfg_access_sva (.clock(clock), .rstn(rstn), .req_valid(l1.req_valid),
      .req_ready(l1.req_ready), .req_tok(l1.req_tok), .req_dest(l1.req_dest),
      .rsp_valid(l1.rsp_valid), .rsp_ready(l1.rsp_ready), .rsp_tok(l1.rsp_tok));

   always #2 clock = ~clock;

   // Watch both links; the raw queue advances only on an accepted token
   always @(posedge clock) begin
      if (l1.req_valid && l1.req_ready) begin
         q1.push_back(l1.req_tok);
         dest1 = l1.req_dest;
      end
      if (l1.rsp_valid && l1.rsp_ready) begin
         rcnt1++;
         rdest1 = l1.rsp_dest;
      end
      if (l2.rsp_valid && l2.rsp_ready) rx2.push_back(l2.rsp_tok);
      if (l2.req_valid && l2.req_ready) void'(tx2.pop_front());
   end

   // Raw driver; an idle token line toggles so no stale value looks valid
   always @(negedge clock) begin
      l2.req_valid = tx2.size() != 0;
      l2.req_tok = (tx2.size() != 0) ? tx2[0] : ~l2.req_tok;
      l2.req_dest = dest2;
      l2.rsp_ready = rsp_ready2;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic do_cmd(input row_t x);
      int j;
      cmd_write = x.w;
      cmd_reg = x.r;
      cmd_wdata = x.d;
      cmd_reply_id = x.id;
      cmd_valid = 1;
      for (j = 0; j < 100 && !cmd_ready; j++) @(negedge clock);
      @(negedge clock);
      cmd_valid = 0;
      for (j = 0; j < 300 && !res_valid; j++) @(negedge clock);
      chk("res_valid", 1, res_valid);
      chk("res_ok", x.ok, res_ok);
      if (x.ok && !x.w) chk("res_rdata", x.rd, res_rdata);
   endtask : do_cmd

   task automatic ps_op(input logic w, input logic [31:0] id, input logic [31:0] wd,
      input logic er, input logic [31:0] rd);
      ps_valid = 1;
      ps_write = w;
      ps_resid = id;
      ps_wdata = wd;
      @(negedge clock);
      chk("ps_ack", 1, ps_ack);
      chk("ps_err", er, ps_err);
      if (!w && !er) chk("ps_rdata", rd, ps_rdata);
   endtask : ps_op

   task automatic rx_cmp(input logic [8:0] e[$]);
      int j;
      for (j = 0; j < 400 && rx2.size() < e.size(); j++) @(negedge clock);
      chk("rx_count", 32'(e.size()), 32'(rx2.size()));
      foreach (e[i]) chk("rsp_tok", e[i], rx2[i]);
      rx2.delete();
   endtask : rx_cmp

   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   // Hang guard well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      l2.req_valid = 0;
      l2.req_tok = '0;
      l2.req_dest = dest2;
      l2.rsp_ready = 1;
      rows = '{'{1, 16'h0000, 32'hA1B2C3D4, 24'h12345A, 1, 0},
         '{0, 16'h0000, 0, 24'h12345A, 1, 32'hA1B2C3D4},
         '{1, 16'h000F, 32'h5566778F, 24'h00AB01, 1, 0},
         '{0, 16'h000F, 0, 24'h00AB01, 1, 32'h5566778F},
         '{1, 16'h0010, 32'h00000001, 24'h000102, 0, 0},
         '{0, 16'h0010, 0, 24'h000102, 0, 0},
         '{0, 16'hFFFF, 0, 24'h000102, 0, 0},
         '{1, 16'h0005, 32'hCAFE0001, 24'h4321FF, 1, 0},
         '{0, 16'h0005, 0, 24'h432100, 1, 32'hCAFE0001}};
      repeat (12) @(negedge clock);
      rstn = 1;
      @(negedge clock);
      foreach (rows[i]) begin
         n = rcnt1;
         tgt = 16'h4200 + 16'(i);
         do_cmd(rows[i]);
         repeat (20) @(negedge clock);
         if (rows[i].id[7:0] == 8'hFF) chk("reply_count", n, rcnt1);
         else chk("rsp_dest", rows[i].id, rdest1);
         if (i == 0) foreach (wr_exp[j]) chk("req_tok", wr_exp[j], q1[j]);
         if (i == 0) chk("req_dest", {16'h4200, TILE_DEST_LOW}, dest1);
      end
      // Status port, back to back, then bad identifiers
      ps_op(1, 32'h0000000B, 32'h89ABCDEF, 0, 0);
      ps_op(1, 32'h00000F0B, 32'h01234567, 0, 0);
      ps_op(0, 32'h0000000B, 0, 0, 32'h89ABCDEF);
      ps_op(0, 32'h00000F0B, 0, 0, 32'h01234567);
      ps_op(0, 32'h00000F0C, 0, 1, 0);
      ps_op(0, 32'h0000100B, 0, 1, 0);
      // Strobe is lowered once after the burst so it never toggles within one step
      ps_valid = 0;
      @(negedge clock);
      chk("ps_ack_idle", 0, ps_ack);
      // Node bank over the raw link: write, read back, truncated read
      tx2 = {tx2, 9'h1C0, 9'h000, 9'h010, 9'h020, 9'h000, 9'h003, 9'h011, 9'h022, 9'h033,
         9'h044, 9'h101};
      rx_cmp({9'h103, 9'h101});
      tx2 = {tx2, 9'h1C1, 9'h000, 9'h010, 9'h020, 9'h000, 9'h003, 9'h101};
      rx_cmp({9'h103, 9'h011, 9'h022, 9'h033, 9'h044, 9'h101});
      tx2 = {tx2, 9'h1C1, 9'h000, 9'h010, 9'h020, 9'h101};
      rx_cmp({9'h104, 9'h101});
      // Stray control token mid-field: skip to the end token, then fail
      tx2 = {tx2, 9'h1C1, 9'h000, 9'h010, 9'h020, 9'h104, 9'h101};
      rx_cmp({9'h104, 9'h101});
      // Wrong bank destination is dropped silently
      dest2 = 32'h0000C20C;
      tx2 = {tx2, 9'h1C1, 9'h000, 9'h010, 9'h020, 9'h000, 9'h003, 9'h101};
      repeat (60) @(negedge clock);
      chk("drop_count", 0, 32'(rx2.size()));
      dest2 = 32'h0000C30C;
      // Stalled replies let the request buffer fill until it refuses
      rsp_ready2 = 0;
      ex.delete();
      for (k = 0; k < 6; k++) begin
         tx2 = {tx2, 9'h1C1, 9'h000, 9'h010, 9'h020, 9'h000, 9'h003, 9'h101};
         ex = {ex, 9'h103, 9'h011, 9'h022, 9'h033, 9'h044, 9'h101};
      end
      for (k = 0; k < 200 && l2.req_ready; k++) @(negedge clock);
      chk("fifo_full", 0, l2.req_ready);
      rsp_ready2 = 1;
      rx_cmp(ex);
      chk("fifo_left", 0, 32'(tx2.size()));
      // Reset in mid-run clears outputs but keeps bank contents
      rstn = 0;
      repeat (2) @(negedge clock);
      chk("cmd_ready_rst", 0, cmd_ready);
      chk("rsp_valid_rst", 0, l1.rsp_valid);
      rstn = 1;
      repeat (2) @(negedge clock);
      do_cmd(rows[1]);
      // Node-bank destination from the requester; suppressed write so no reply is awaited
      node = 1;
      do_cmd('{1, 16'h0002, 32'h00000001, 24'h0000FF, 1, 0});
      chk("req_dest_node", {tgt, NODE_DEST_LOW}, dest1);
      report_and_stop();
   end
endmodule : test_config_register_access_protocol
